/* core/dsau_pkg.sv */
package dsau_pkg;
   localparam int EA_W = 16;
   // region limits (byte addresses)
   localparam logic [15:0] SFR_LIMIT  = 16'h1000;
   localparam logic [15:0] RAM_BASE   = 16'h1000;
   localparam logic [15:0] Y_BASE_DEF = 16'h9000;
   localparam logic [15:0] MEM_LIMIT  = 16'he000;
   localparam logic [15:0] DMA_SIZE   = 16'h1000;
   localparam int          NEAR_W     = 13;
   localparam int          DMA_AW     = 11;
   localparam int          MAIN_AW    = 15;
   localparam logic [15:0] STEP_BYTE  = 16'h0001;
   localparam logic [15:0] STEP_WORD  = 16'h0002;
   // core register offsets
   localparam logic [15:0] OFF_STATUS = 16'h0042;
   localparam logic [15:0] OFF_CORCTL = 16'h0044;
   localparam logic [15:0] OFF_MODCTL = 16'h0046;
   localparam logic [15:0] OFF_XMSRT  = 16'h0048;
   localparam logic [15:0] OFF_XMEND  = 16'h004a;
   localparam logic [15:0] OFF_YMSRT  = 16'h004c;
   localparam logic [15:0] OFF_YMEND  = 16'h004e;
   localparam logic [15:0] OFF_BREV   = 16'h0050;
   localparam logic [15:0] OFF_DISCNT = 16'h0052;
   localparam logic [15:0] OFF_TBLPG  = 16'h0054;
   localparam logic [15:0] OFF_MSTPRI = 16'h0058;
   // reset values
   localparam logic [15:0] RST_ZERO   = 16'h0000;
   localparam logic [15:0] RST_CORCTL = 16'h0020;
   localparam logic [15:0] RST_MODEND = 16'h0001;
   // writable masks and forced-one bits
   localparam logic [15:0] MSK_ALL    = 16'hffff;
   localparam logic [15:0] MSK_MODBND = 16'hfffe;
   localparam logic [15:0] SET_MODEND = 16'h0001;
   localparam logic [15:0] MSK_DISCNT = 16'h3fff;
   localparam logic [15:0] MSK_TBLPG  = 16'h00ff;
   // modulo_control and bit_reverse_control fields
   localparam int MOD_XEN  = 15;
   localparam int MOD_YEN  = 14;
   localparam int MOD_BWM  = 8;
   localparam int MOD_YWM  = 4;
   localparam int MOD_XWM  = 0;
   localparam int BREV_EN  = 15;
   localparam logic [3:0] WSEL_NONE = 4'hf;

   typedef enum logic [1:0] {
      DSAU_IND     = 2'b00,
      DSAU_POSTINC = 2'b01,
      DSAU_DIR13   = 2'b10,
      DSAU_DIR16   = 2'b11
   } dsau_mode_e;
endpackage

/* core/dsau_agu.sv */
`timescale 1ns/1ps
`default_nettype none
module dsau_agu #(
   parameter bit DSP_EN = 1'b1
) (
   // request
   input  wire dsau_pkg::dsau_mode_e mode,
   input  wire logic [15:0]          ptr,
   input  wire logic [3:0]           ptr_sel,
   input  wire logic [15:0]          lit,
   input  wire logic                 byte_op,
   input  wire logic                 brev_ok,
   // addressing controls
   input  wire logic                 mod_en,
   input  wire logic [3:0]           mod_wsel,
   input  wire logic [15:0]          mod_start,
   input  wire logic [15:0]          mod_end,
   input  wire logic                 brev_en,
   input  wire logic [3:0]           brev_wsel,
   input  wire logic [14:0]          brev_mod,
   // result
   output logic      [15:0]          ea,
   output logic      [15:0]          ptr_next
);
   import dsau_pkg::*;

   function automatic logic [15:0] rev16(input logic [15:0] v);
      logic [15:0] r;
      for (int i = 0; i < 16; i++) begin
         r[i] = v[15 - i];
      end
      return r;
   endfunction

   logic [15:0] step;
   logic [15:0] inc;
   logic [15:0] rev_add;

   always_comb begin
      step    = byte_op ? STEP_BYTE : STEP_WORD;
      inc     = ptr + step;
      rev_add = rev16(rev16(ptr) + rev16({1'b0, brev_mod}));
      unique case (mode)
         DSAU_DIR13: ea = {{(16 - NEAR_W){1'b0}}, lit[NEAR_W-1:0]};
         DSAU_DIR16: ea = lit;
         default:    ea = ptr;
      endcase
      ptr_next = ptr;
      if (mode == DSAU_POSTINC) begin
         // modulo only on the DSP variant
         if (DSP_EN && mod_en && ptr_sel == mod_wsel && ptr_sel != WSEL_NONE && inc > mod_end) begin
            ptr_next = mod_start;
         end else if (DSP_EN && brev_ok && brev_en && !byte_op && ptr_sel == brev_wsel
                      && ptr_sel != WSEL_NONE) begin
            ptr_next = rev_add;
         end else begin
            ptr_next = inc;
         end
      end
   end
endmodule // dsau_agu
`default_nettype wire

/* core/dsau_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - post-increment adds 1 for byte, 2 for word operations.
// - byte read fetches whole word, address bit 0 picks byte, placed low.
// - shared word decode, separate byte-lane write strobes.
// - word access at odd address raises address error trap; Y reads at an odd address raise none.
// - misaligned read completes, misaligned write suppressed; trap follows.
// - byte load into working register keeps its high byte.
// - lowest 4 Kbytes hold registers; unimplemented ones read zero.
// - 13-bit direct field reaches the lowest 8 Kbytes.
// - 16-bit direct field or pointer reaches the whole space.
// - DSP variant has separate X and Y generators for dual fetch.
// - non-DSP variant has no Y space; all is X.
// - X has separate read and write buses; X read serves all.
// - Y supplies a second concurrent operand for multiply-accumulate.
// - modulo in X and Y, bit-reverse on X writes, none without DSP.
// - all writes use combined map; X/Y boundary fixed.
// - 4 Kbyte dual-ported DMA RAM at top, shared without stealing cycles.
// - same-location concurrent writes: CPU wins, CPU never stalls.
// - access outside implemented memory returns zero.
// - 16-bit byte addresses, low byte even, high byte odd.
module dsau_top
   import dsau_pkg::*;
#(
   parameter bit          DSP_EN = 1'b1,
   parameter logic [15:0] Y_BASE = dsau_pkg::Y_BASE_DEF
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  nrst,
   // X read request
   input  wire logic                  xr_valid,
   input  wire dsau_pkg::dsau_mode_e  xr_mode,
   input  wire logic [15:0]           xr_ptr,
   input  wire logic [3:0]            xr_ptr_sel,
   input  wire logic [15:0]           xr_lit,
   input  wire logic                  xr_byte,
   input  wire logic [15:0]           xr_wreg_old,
   // X read answer
   output logic      [15:0]           xr_data,
   output logic      [15:0]           xr_wreg,
   output logic      [15:0]           xr_ptr_next,
   // Y read request and answer
   input  wire logic                  yr_valid,
   input  wire dsau_pkg::dsau_mode_e  yr_mode,
   input  wire logic [15:0]           yr_ptr,
   input  wire logic [3:0]            yr_ptr_sel,
   output logic      [15:0]           yr_data,
   output logic      [15:0]           yr_ptr_next,
   // X write request and answer
   input  wire logic                  wr_valid,
   input  wire dsau_pkg::dsau_mode_e  wr_mode,
   input  wire logic [15:0]           wr_ptr,
   input  wire logic [3:0]            wr_ptr_sel,
   input  wire logic [15:0]           wr_lit,
   input  wire logic                  wr_byte,
   input  wire logic [15:0]           wr_data,
   output logic      [15:0]           wr_ptr_next,
   // address error to exception logic
   output logic                       addr_err,
   output logic                       addr_err_write,
   // DMA controller port
   input  wire logic                  dma_rd,
   input  wire logic                  dma_wr,
   input  wire logic [10:0]           dma_addr,
   input  wire logic [1:0]            dma_be,
   input  wire logic [15:0]           dma_wdata,
   output logic      [15:0]           dma_rdata
);
   import dsau_pkg::*;

   localparam logic [15:0] DMA_BASE = MEM_LIMIT - DMA_SIZE;
   localparam int MAIN_WORDS = int'((DMA_BASE - RAM_BASE) >> 1);
   localparam int DMA_WORDS  = 1 << DMA_AW;

   typedef struct packed {
      logic [15:0] status;
      logic [15:0] corctl;
      logic [15:0] modctl;
      logic [15:0] xmsrt;
      logic [15:0] xmend;
      logic [15:0] ymsrt;
      logic [15:0] ymend;
      logic [15:0] brev;
      logic [15:0] discnt;
      logic [15:0] tblpg;
      logic [15:0] mstpri;
      logic [15:0] xr_data;
      logic [15:0] xr_wreg;
      logic [15:0] xr_ptr;
      logic [15:0] yr_data;
      logic [15:0] yr_ptr;
      logic [15:0] wr_ptr;
      logic [15:0] dma_rdata;
      logic        err;
      logic        err_wr;
   } dsau_state_s;

   dsau_state_s s_q;
   dsau_state_s s_d;

   logic [15:0] main_mem [MAIN_WORDS];
   logic [15:0] dma_mem  [DMA_WORDS];

   logic [15:0] xr_ea;
   logic [15:0] yr_ea;
   logic [15:0] wr_ea;
   logic [15:0] xr_pn;
   logic [15:0] yr_pn;
   logic [15:0] wr_pn;
   logic        mis_rd;
   logic        mis_wr;
   logic [1:0]  wr_lanes;
   logic [15:0] wr_word;
   logic [1:0]  main_we;
   logic [1:0]  cpu_dma_we;
   logic [14:0] wr_main_idx;
   logic [15:0] xr_word;
   logic [15:0] yr_word;
   logic [7:0]  xr_sel_byte;

   // read and write generators on the X side; the Y generator is always built, its result used only on the DSP variant
   dsau_agu #(.DSP_EN(DSP_EN)) u_xr_agu (
      .mode      (xr_mode),
      .ptr       (xr_ptr),
      .ptr_sel   (xr_ptr_sel),
      .lit       (xr_lit),
      .byte_op   (xr_byte),
      .brev_ok   (1'b0),
      .mod_en    (s_q.modctl[MOD_XEN]),
      .mod_wsel  (s_q.modctl[MOD_XWM +: 4]),
      .mod_start (s_q.xmsrt),
      .mod_end   (s_q.xmend),
      .brev_en   (s_q.brev[BREV_EN]),
      .brev_wsel (s_q.modctl[MOD_BWM +: 4]),
      .brev_mod  (s_q.brev[14:0]),
      .ea        (xr_ea),
      .ptr_next  (xr_pn)
   );

   dsau_agu #(.DSP_EN(DSP_EN)) u_wr_agu (
      .mode      (wr_mode),
      .ptr       (wr_ptr),
      .ptr_sel   (wr_ptr_sel),
      .lit       (wr_lit),
      .byte_op   (wr_byte),
      .brev_ok   (1'b1),
      .mod_en    (s_q.modctl[MOD_XEN]),
      .mod_wsel  (s_q.modctl[MOD_XWM +: 4]),
      .mod_start (s_q.xmsrt),
      .mod_end   (s_q.xmend),
      .brev_en   (s_q.brev[BREV_EN]),
      .brev_wsel (s_q.modctl[MOD_BWM +: 4]),
      .brev_mod  (s_q.brev[14:0]),
      .ea        (wr_ea),
      .ptr_next  (wr_pn)
   );

   dsau_agu #(.DSP_EN(DSP_EN)) u_yr_agu (
      .mode      (yr_mode),
      .ptr       (yr_ptr),
      .ptr_sel   (yr_ptr_sel),
      .lit       (16'h0000),
      .byte_op   (1'b0),
      .brev_ok   (1'b0),
      .mod_en    (s_q.modctl[MOD_YEN]),
      .mod_wsel  (s_q.modctl[MOD_YWM +: 4]),
      .mod_start (s_q.ymsrt),
      .mod_end   (s_q.ymend),
      .brev_en   (1'b0),
      .brev_wsel (WSEL_NONE),
      .brev_mod  (15'h0000),
      .ea        (yr_ea),
      .ptr_next  (yr_pn)
   );

   // registers that only exist with the DSP engine
   function automatic logic dsp_only(input logic [15:0] a);
      return a >= OFF_MODCTL && a <= OFF_BREV;
   endfunction

   function automatic logic [15:0] sfr_rd(input logic [15:0] ea);
      logic [15:0] a;
      logic [15:0] v;
      a = {ea[15:1], 1'b0};
      v = 16'h0000;
      unique case (a)
         OFF_STATUS: v = s_q.status;
         OFF_CORCTL: v = s_q.corctl;
         OFF_MODCTL: v = s_q.modctl;
         OFF_XMSRT:  v = s_q.xmsrt;
         OFF_XMEND:  v = s_q.xmend;
         OFF_YMSRT:  v = s_q.ymsrt;
         OFF_YMEND:  v = s_q.ymend;
         OFF_BREV:   v = s_q.brev;
         OFF_DISCNT: v = s_q.discnt;
         OFF_TBLPG:  v = s_q.tblpg;
         OFF_MSTPRI: v = s_q.mstpri;
         default:    v = 16'h0000;
      endcase
      if (!DSP_EN && dsp_only(a)) begin
         v = 16'h0000;
      end
      return v;
   endfunction

   // one word decode for the whole map; byte choice is done afterwards
   function automatic logic [15:0] mem_rd(input logic [15:0] ea);
      logic [15:0] off;
      logic [15:0] v;
      off = ea - RAM_BASE;
      v   = 16'h0000;
      if (ea < SFR_LIMIT) begin
         v = sfr_rd(ea);
      end else if (ea < DMA_BASE) begin
         v = main_mem[off[15:1]];
      end else if (ea < MEM_LIMIT) begin
         v = dma_mem[ea[DMA_AW:1]];
      end else begin
         v = 16'h0000;
      end
      return v;
   endfunction

   function automatic logic [15:0] lane_wr(input logic [15:0] old, input logic [15:0] nv,
                                           input logic [1:0] ln, input logic [15:0] msk,
                                           input logic [15:0] set);
      logic [15:0] m;
      m = {{8{ln[1]}}, {8{ln[0]}}} & msk;
      return (old & ~m) | (nv & m) | set;
   endfunction

   always_comb begin
      // misaligned word: read still completes, write is dropped
      mis_rd      = xr_valid && !xr_byte && xr_ea[0];
      mis_wr      = wr_valid && !wr_byte && wr_ea[0];
      wr_lanes    = wr_byte ? {wr_ea[0], ~wr_ea[0]} : 2'b11;
      if (!wr_valid || mis_wr) begin
         wr_lanes = 2'b00;
      end
      wr_word     = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
      wr_main_idx = MAIN_AW'((wr_ea - RAM_BASE) >> 1);
      main_we     = (wr_ea >= RAM_BASE && wr_ea < DMA_BASE) ? wr_lanes : 2'b00;
      cpu_dma_we  = (wr_ea >= DMA_BASE && wr_ea < MEM_LIMIT) ? wr_lanes : 2'b00;
      xr_word     = mem_rd({xr_ea[15:1], 1'b0});
      yr_word     = mem_rd({yr_ea[15:1], 1'b0});
      xr_sel_byte = xr_ea[0] ? xr_word[15:8] : xr_word[7:0];

      s_d = s_q;
      if (xr_valid) begin
         s_d.xr_data = xr_byte ? {8'h00, xr_sel_byte} : xr_word;
         s_d.xr_wreg = xr_byte ? {xr_wreg_old[15:8], xr_sel_byte} : xr_word;
         s_d.xr_ptr  = xr_pn;
      end
      // Y reads see only the RAM from Y_BASE upward
      if (yr_valid) begin
         s_d.yr_data = (DSP_EN && yr_ea >= Y_BASE) ? yr_word : 16'h0000;
         s_d.yr_ptr  = DSP_EN ? yr_pn : yr_ptr;
      end
      if (wr_valid) begin
         s_d.wr_ptr = wr_pn;
      end
      s_d.err    = mis_rd || mis_wr;
      s_d.err_wr = mis_wr;
      if (dma_rd) begin
         s_d.dma_rdata = dma_mem[dma_addr];
      end

      if (wr_ea < SFR_LIMIT && wr_lanes != 2'b00 && (DSP_EN || !dsp_only({wr_ea[15:1], 1'b0}))) begin
         unique case ({wr_ea[15:1], 1'b0})
            OFF_STATUS: s_d.status = lane_wr(s_q.status, wr_word, wr_lanes, MSK_ALL, RST_ZERO);
            OFF_CORCTL: s_d.corctl = lane_wr(s_q.corctl, wr_word, wr_lanes, MSK_ALL, RST_ZERO);
            OFF_MODCTL: s_d.modctl = lane_wr(s_q.modctl, wr_word, wr_lanes, MSK_ALL, RST_ZERO);
            OFF_XMSRT:  s_d.xmsrt  = lane_wr(s_q.xmsrt, wr_word, wr_lanes, MSK_MODBND, RST_ZERO);
            OFF_XMEND:  s_d.xmend  = lane_wr(s_q.xmend, wr_word, wr_lanes, MSK_MODBND, SET_MODEND);
            OFF_YMSRT:  s_d.ymsrt  = lane_wr(s_q.ymsrt, wr_word, wr_lanes, MSK_MODBND, RST_ZERO);
            OFF_YMEND:  s_d.ymend  = lane_wr(s_q.ymend, wr_word, wr_lanes, MSK_MODBND, SET_MODEND);
            OFF_BREV:   s_d.brev   = lane_wr(s_q.brev, wr_word, wr_lanes, MSK_ALL, RST_ZERO);
            OFF_DISCNT: s_d.discnt = lane_wr(s_q.discnt, wr_word, wr_lanes, MSK_DISCNT, RST_ZERO);
            OFF_TBLPG:  s_d.tblpg  = lane_wr(s_q.tblpg, wr_word, wr_lanes, MSK_TBLPG, RST_ZERO);
            OFF_MSTPRI: s_d.mstpri = lane_wr(s_q.mstpri, wr_word, wr_lanes, MSK_ALL, RST_ZERO);
            default:    s_d.status = s_d.status;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         s_q        <= '0;
         s_q.corctl <= RST_CORCTL;
         s_q.xmend  <= RST_MODEND;
         s_q.ymend  <= RST_MODEND;
      end else begin
         s_q <= s_d;
      end
   end

   // byte-lane write strobes; the CPU write is issued last so it wins a shared lane
   // one process owns both arrays, so no array has two drivers
   always_ff @(posedge clock) begin
      for (int l = 0; l < 2; l++) begin
         if (main_we[l]) begin
            main_mem[wr_main_idx][l*8 +: 8] <= wr_word[l*8 +: 8];
         end
         if (dma_wr && dma_be[l]) begin
            dma_mem[dma_addr][l*8 +: 8] <= dma_wdata[l*8 +: 8];
         end
         if (cpu_dma_we[l]) begin
            dma_mem[wr_ea[DMA_AW:1]][l*8 +: 8] <= wr_word[l*8 +: 8];
         end
      end
   end

   assign xr_data        = s_q.xr_data;
   assign xr_wreg        = s_q.xr_wreg;
   assign xr_ptr_next    = s_q.xr_ptr;
   assign yr_data        = s_q.yr_data;
   assign yr_ptr_next    = s_q.yr_ptr;
   assign wr_ptr_next    = s_q.wr_ptr;
   assign addr_err       = s_q.err;
   assign addr_err_write = s_q.err_wr;
   assign dma_rdata      = s_q.dma_rdata;
endmodule // dsau_top
`default_nettype wire

/* verif/dsau_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module dsau_top_monitor
   import dsau_pkg::*;
#(parameter logic [15:0] Y_BASE = Y_BASE_DEF) (
   // clock and reset
   input wire logic clock, nrst,
   // requests
   input wire logic xr_valid, xr_byte, yr_valid, wr_valid, wr_byte, dma_wr,
   input wire dsau_pkg::dsau_mode_e xr_mode, yr_mode, wr_mode,
   input wire logic [15:0] xr_ptr, xr_lit, xr_wreg_old, yr_ptr, wr_ptr, wr_lit,
   input wire logic [3:0] xr_ptr_sel, wr_ptr_sel,
   // answers
   input wire logic [15:0] xr_data, xr_wreg, yr_data, xr_ptr_next, wr_ptr_next,
   input wire logic addr_err, addr_err_write
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   a_rd_misalign: assert property (xr_valid && !xr_byte && xr_mode == DSAU_DIR16 && xr_lit[0] && !wr_valid
      |=> addr_err && !addr_err_write) else $error("read misalign missed");
   a_wr_misalign: assert property (wr_valid && !wr_byte && wr_mode == DSAU_DIR16 && wr_lit[0]
      |=> addr_err && addr_err_write) else $error("write misalign missed");
   a_err_cause: assert property (!(xr_valid && !xr_byte) && !(wr_valid && !wr_byte)
      |=> !addr_err) else $error("address error without cause");
   a_pinc_byte: assert property (xr_valid && xr_mode == DSAU_POSTINC && xr_byte && xr_ptr_sel == WSEL_NONE
      |=> xr_ptr_next == $past(xr_ptr) + STEP_BYTE) else $error("byte step wrong");
   a_pinc_word: assert property (wr_valid && wr_mode == DSAU_POSTINC && !wr_byte && wr_ptr_sel == WSEL_NONE
      |=> wr_ptr_next == $past(wr_ptr) + STEP_WORD) else $error("word step wrong");
   a_byte_lane: assert property (xr_valid && xr_byte |=> xr_data[15:8] == 8'h00)
      else $error("byte not on low lane");
   a_byte_merge: assert property (xr_valid && xr_byte |=> ((xr_wreg ^ $past(xr_wreg_old)) & 16'hff00) == 16'h0000
      && xr_wreg[7:0] == xr_data[7:0]) else $error("byte load merge wrong");
   a_range_zero: assert property (xr_valid && xr_mode == DSAU_DIR16 && xr_lit >= MEM_LIMIT
      |=> xr_data == 16'h0000) else $error("unimplemented read not zero");
   a_y_below: assert property (yr_valid && yr_mode == DSAU_IND && yr_ptr < Y_BASE
      |=> yr_data == 16'h0000) else $error("y read below base not zero");
   c_werr: cover property (wr_valid && !wr_byte && wr_lit[0]);
   c_dual: cover property (xr_valid && yr_valid);
   c_clash: cover property (wr_valid && dma_wr);
endmodule // dsau_top_monitor
`default_nettype wire

/* verif/dsau_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dsau_dma_model (
   // clock
   input wire logic clock,
   // dma port of the block
   input wire logic [15:0] dma_rdata,
   output var logic dma_rd, dma_wr,
   output var logic [10:0] dma_addr,
   output var logic [1:0] dma_be,
   output var logic [15:0] dma_wdata
);
   initial {dma_rd, dma_wr, dma_addr, dma_be, dma_wdata} = '0;
   // no ready exists: every request is taken at the next edge
   task automatic put(input logic [10:0] a, input logic [1:0] be, input logic [15:0] d);
      @(posedge clock);
      {dma_wr, dma_be} <= {1'b1, be};
      {dma_addr, dma_wdata} <= {a, d};
      @(posedge clock);
      dma_wr <= 1'b0;
      {dma_addr, dma_wdata} <= {~a, ~d};
   endtask
   task automatic get(input logic [10:0] a, output logic [15:0] d);
      @(posedge clock);
      {dma_rd, dma_addr} <= {1'b1, a};
      @(posedge clock);
      {dma_rd, dma_addr} <= {1'b0, ~a};
      #1;
      d = dma_rdata;
   endtask
endmodule // dsau_dma_model
`default_nettype wire

/* verif/dsau_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dsau_top_tb;
   import dsau_pkg::*;
   logic clock, nrst, xr_valid, xr_byte, yr_valid, wr_valid, wr_byte, dma_rd, dma_wr, addr_err, addr_err_write;
   logic [15:0] xr_ptr, xr_lit, xr_wreg_old, yr_ptr, wr_ptr, wr_lit, wr_data, dma_wdata, dma_rdata;
   logic [15:0] xr_data, xr_wreg, xr_ptr_next, yr_data, yr_ptr_next, wr_ptr_next;
   logic [3:0] xr_ptr_sel, yr_ptr_sel, wr_ptr_sel;
   logic [10:0] dma_addr;
   logic [1:0] dma_be;
   dsau_mode_e xr_mode, yr_mode, wr_mode;
   int failures, checks;
   logic [15:0] roff [11] = '{16'h42, 16'h44, 16'h46, 16'h48, 16'h4a, 16'h4c, 16'h4e, 16'h50, 16'h52, 16'h54, 16'h58};
   logic [15:0] rrst [11] = '{16'h0, 16'h20, 16'h0, 16'h0, 16'h1, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0, 16'h0};

   dsau_top i_dsau_top (.clock, .nrst, .xr_valid, .xr_mode, .xr_ptr, .xr_ptr_sel, .xr_lit, .xr_byte,
      .xr_wreg_old, .xr_data, .xr_wreg, .xr_ptr_next, .yr_valid, .yr_mode, .yr_ptr, .yr_ptr_sel, .yr_data,
      .yr_ptr_next, .wr_valid, .wr_mode, .wr_ptr, .wr_ptr_sel, .wr_lit, .wr_byte, .wr_data, .wr_ptr_next,
      .addr_err, .addr_err_write, .dma_rd, .dma_wr, .dma_addr, .dma_be, .dma_wdata, .dma_rdata);
   dsau_dma_model i_dsau_dma_model (.clock, .dma_rdata, .dma_rd, .dma_wr, .dma_addr, .dma_be, .dma_wdata);

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask

   task automatic xrd(input dsau_mode_e m, input logic [15:0] a, input logic b);
      @(posedge clock);
      {xr_valid, xr_byte, xr_ptr, xr_lit} <= {1'b1, b, a, a};
      xr_mode <= m;
      @(posedge clock);
      xr_valid <= 1'b0;
      #1;
   endtask

   task automatic xwr(input dsau_mode_e m, input logic [15:0] a, input logic b, input logic [15:0] d);
      @(posedge clock);
      {wr_valid, wr_byte, wr_ptr, wr_lit, wr_data} <= {1'b1, b, a, a, d};
      wr_mode <= m;
      @(posedge clock);
      wr_valid <= 1'b0;
      #1;
   endtask

   task automatic t_regs;
      for (int i = 0; i < 11; i++) begin
         xrd(DSAU_DIR16, roff[i], 1'b0);
         chk("reg_reset", xr_data, rrst[i]);
      end
      xrd(DSAU_DIR16, 16'h0056, 1'b0);
      chk("sfr_gap", xr_data, 16'h0000);
      xrd(DSAU_DIR13, 16'he044, 1'b0);
      chk("near13", xr_data, 16'h0020);
      xwr(DSAU_DIR16, 16'h0054, 1'b0, 16'hffff);
      xwr(DSAU_DIR16, 16'h004a, 1'b0, 16'h0000);
      xwr(DSAU_DIR16, 16'he000, 1'b0, 16'hffff);
      xrd(DSAU_DIR16, 16'h0054, 1'b0);
      chk("page_mask", xr_data, 16'h00ff);
      xrd(DSAU_DIR16, 16'h004a, 1'b0);
      chk("modend_b0", xr_data, 16'h0001);
      xrd(DSAU_DIR16, 16'he000, 1'b0);
      chk("beyond", xr_data, 16'h0000);
   endtask

   task automatic t_lanes;
      xwr(DSAU_DIR16, 16'h1000, 1'b0, 16'h1234);
      xwr(DSAU_DIR16, 16'h1001, 1'b1, 16'h00ab);
      xrd(DSAU_IND, 16'h1000, 1'b0);
      chk("lane_word", xr_data, 16'hab34);
      xrd(DSAU_DIR16, 16'h1001, 1'b1);
      chk("byte_odd", xr_data, 16'h00ab);
      chk("wreg_merge", xr_wreg, 16'h5aab);
      xrd(DSAU_DIR16, 16'h1000, 1'b1);
      chk("byte_even", xr_data, 16'h0034);
   endtask

   task automatic t_misalign;
      xwr(DSAU_DIR16, 16'h1002, 1'b0, 16'h7788);
      xwr(DSAU_DIR16, 16'h1003, 1'b0, 16'h5555);
      chk("werr", 16'(addr_err), 16'h1);
      chk("werr_dir", 16'(addr_err_write), 16'h1);
      xrd(DSAU_DIR16, 16'h1002, 1'b0);
      chk("suppressed", xr_data, 16'h7788);
      xrd(DSAU_DIR16, 16'h1003, 1'b0);
      chk("misread", xr_data, 16'h7788);
      chk("rerr", 16'(addr_err), 16'h1);
      chk("rerr_dir", 16'(addr_err_write), 16'h0);
   endtask

   task automatic t_postinc;
      xrd(DSAU_POSTINC, 16'h1000, 1'b1);
      chk("inc_rb", xr_ptr_next, 16'h1001);
      xrd(DSAU_POSTINC, 16'h1000, 1'b0);
      chk("inc_rw", xr_ptr_next, 16'h1002);
      xwr(DSAU_POSTINC, 16'h1010, 1'b1, 16'h0011);
      chk("inc_wb", wr_ptr_next, 16'h1011);
      xwr(DSAU_POSTINC, 16'h1010, 1'b0, 16'h2233);
      chk("inc_ww", wr_ptr_next, 16'h1012);
      xwr(DSAU_DIR16, 16'h0048, 1'b0, 16'h1000);
      xwr(DSAU_DIR16, 16'h004a, 1'b0, 16'h1002);
      xwr(DSAU_DIR16, 16'h0050, 1'b0, 16'h8008);
      xwr(DSAU_DIR16, 16'h0046, 1'b0, 16'h8201);
      {xr_ptr_sel, wr_ptr_sel} <= 8'h12;
      xrd(DSAU_POSTINC, 16'h1002, 1'b0);
      chk("mod_wrap", xr_ptr_next, 16'h1000);
      xwr(DSAU_POSTINC, 16'h1008, 1'b0, 16'h0000);
      chk("rev_step", wr_ptr_next, 16'h1004);
      {xr_ptr_sel, wr_ptr_sel} <= {2{WSEL_NONE}};
   endtask

   task automatic t_dual;
      xwr(DSAU_DIR16, 16'h9000, 1'b0, 16'hbeef);
      @(posedge clock);
      {xr_valid, xr_byte, xr_lit, yr_valid, yr_ptr} <= {2'b10, 16'h1002, 1'b1, 16'h9000};
      xr_mode <= DSAU_DIR16;
      yr_mode <= DSAU_POSTINC;
      @(posedge clock);
      {xr_valid, yr_valid} <= 2'b00;
      #1;
      chk("dual_x", xr_data, 16'h7788);
      chk("dual_y", yr_data, 16'hbeef);
      chk("y_inc", yr_ptr_next, 16'h9002);
      @(posedge clock);
      {yr_valid, yr_ptr} <= {1'b1, 16'h1000};
      yr_mode <= DSAU_IND;
      @(posedge clock);
      yr_valid <= 1'b0;
      #1;
      chk("y_below", yr_data, 16'h0000);
   endtask

   task automatic t_dma;
      logic [15:0] d;
      i_dsau_dma_model.put(11'd5, 2'b11, 16'h1111);
      xrd(DSAU_DIR16, 16'hd00a, 1'b0);
      chk("dma_cpu", xr_data, 16'h1111);
      xwr(DSAU_DIR16, 16'hd00e, 1'b0, 16'h4242);
      i_dsau_dma_model.get(11'd7, d);
      chk("cpu_dma", d, 16'h4242);
      fork
         xwr(DSAU_DIR16, 16'hd00a, 1'b0, 16'hc0de);
         i_dsau_dma_model.put(11'd5, 2'b11, 16'hdead);
      join
      i_dsau_dma_model.get(11'd5, d);
      chk("clash_word", d, 16'hc0de);
      fork
         xwr(DSAU_DIR16, 16'hd00d, 1'b1, 16'h0022);
         i_dsau_dma_model.put(11'd6, 2'b11, 16'h9988);
      join
      i_dsau_dma_model.get(11'd6, d);
      chk("clash_lane", d, 16'h2288);
   endtask

   task automatic finish_test;
      if (failures == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      {nrst, xr_valid, xr_byte, yr_valid, wr_valid, wr_byte} = '0;
      {xr_ptr, xr_lit, yr_ptr, wr_ptr, wr_lit, wr_data} = '0;
      {xr_ptr_sel, yr_ptr_sel, wr_ptr_sel} = {3{WSEL_NONE}};
      xr_mode = DSAU_IND;
      yr_mode = DSAU_IND;
      wr_mode = DSAU_IND;
      xr_wreg_old = 16'h5a5a;
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      t_regs;
      t_lanes;
      t_misalign;
      t_postinc;
      t_dual;
      t_dma;
      finish_test;
   end

   // the whole sequence needs about 110 cycles
   initial begin
      #(100 * 3000);
      failures++;
      finish_test;
   end
endmodule // dsau_top_tb

bind dsau_top dsau_top_monitor #(.Y_BASE(Y_BASE)) i_dsau_top_monitor (.*);
`default_nettype wire
